// ===== rtl/mca_core.sv
`timescale 1ns/1ps
`include "mca_regs.svh"

module mca_core #(
  parameter int CYC_CLKS = `MCA_CYC_CLKS
) (
  // Clock and reset
  input  logic                      mclk,
  input  logic                      arst_n,
  // Program memory bus
  output mca_pkg::mca_pbus_t        progBus,
  input  logic [`MCA_IW_W-1:0]      progData,
  // Data memory bus
  output mca_pkg::mca_dbus_t        dataBus,
  input  logic [`MCA_DW_W-1:0]      dataRdata,
  // Core state view
  output logic [`MCA_DW_W-1:0]      wOut,
  output logic [2:0]                flagsOut
);
  import mca_pkg::*;

  localparam logic [`MCA_PH_W-1:0] PH_LAST = `MCA_PH_W'(CYC_CLKS - 1);
  localparam logic [`MCA_PH_W-1:0] PH_ADDR = `MCA_PH_W'(1);

  mca_state_t st_ff;
  mca_state_t nxt_st;

  mca_op_t     op;
  logic [7:0]  lit;
  logic [7:0]  effAddr;
  logic        isInt;
  logic [7:0]  opnd;
  logic [7:0]  aluA;
  logic [7:0]  aluB;
  logic        aluCin;
  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [7:0]  res;
  logic        resC;
  logic        updC;
  logic        updDC;
  logic        updZ;
  logic        toW;
  logic        toF;
  logic        exec;
  logic        branch;

  function automatic logic readsFile(input mca_op_t o);
    readsFile = !(o inside {OP_ADDLW, OP_SUBLW, OP_MOVLW, OP_GOTO, OP_MOVWF});
  endfunction : readsFile

  function automatic logic isSfr(input logic [7:0] a);
    isSfr = (a == `MCA_ADR_INDF) || (a == `MCA_ADR_PCL) ||
            (a == `MCA_ADR_STATUS) || (a == `MCA_ADR_FSR);
  endfunction : isSfr

  assign op      = mca_op_t'(st_ff.ir[13:10]);
  assign lit     = st_ff.ir[7:0];
  assign exec    = (st_ff.phase == PH_LAST) && st_ff.irValid;
  // Indirect access through the pointer register
  assign effAddr = (lit == `MCA_ADR_INDF) ? st_ff.fsr : lit;
  assign isInt   = isSfr(effAddr);

  // Operand from internal registers or the data bus
  always_comb begin
    unique case (effAddr)
      `MCA_ADR_PCL:    opnd = st_ff.pc[7:0];
      `MCA_ADR_STATUS: opnd = {5'h00, st_ff.flags};
      `MCA_ADR_FSR:    opnd = st_ff.fsr;
      `MCA_ADR_INDF:   opnd = 8'h00;
      default:         opnd = dataRdata;
    endcase
  end

  // Adder operand select, subtraction as A + ~B + 1
  always_comb begin
    aluA   = opnd;
    aluB   = st_ff.w;
    aluCin = 1'b0;
    unique case (op)
      OP_SUBWF: begin
        aluB   = ~st_ff.w;
        aluCin = 1'b1;
      end
      OP_ADDLW: aluA = lit;
      OP_SUBLW: begin
        aluA   = lit;
        aluB   = ~st_ff.w;
        aluCin = 1'b1;
      end
      OP_INCF: begin
        aluB   = 8'h00;
        aluCin = 1'b1;
      end
      OP_DECF:  aluB = 8'hFF;
      default: begin
        aluB   = st_ff.w;
      end
    endcase
  end

  assign sum9 = {1'b0, aluA} + {1'b0, aluB} + {8'h00, aluCin};
  assign nib5 = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]} + {4'h0, aluCin};

  // Result, destination and flag selection
  always_comb begin
    res   = sum9[7:0];
    resC  = sum9[8];
    updC  = 1'b0;
    updDC = 1'b0;
    updZ  = 1'b0;
    toW   = !st_ff.ir[8];
    toF   = st_ff.ir[8];
    unique case (op)
      OP_ADDWF, OP_SUBWF: begin
        updC  = 1'b1;
        updDC = 1'b1;
        updZ  = 1'b1;
      end
      OP_ADDLW, OP_SUBLW: begin
        updC  = 1'b1;
        updDC = 1'b1;
        updZ  = 1'b1;
        toW   = 1'b1;
        toF   = 1'b0;
      end
      OP_ANDWF: begin
        res  = opnd & st_ff.w;
        updZ = 1'b1;
      end
      OP_IORWF: begin
        res  = opnd | st_ff.w;
        updZ = 1'b1;
      end
      OP_XORWF: begin
        res  = opnd ^ st_ff.w;
        updZ = 1'b1;
      end
      OP_MOVF: begin
        res  = opnd;
        updZ = 1'b1;
      end
      OP_COMF: begin
        res  = ~opnd;
        updZ = 1'b1;
      end
      OP_INCF, OP_DECF: updZ = 1'b1;
      OP_RLF: begin
        res  = {opnd[6:0], st_ff.flags[`MCA_ST_C]};
        resC = opnd[7];
        updC = 1'b1;
      end
      OP_RRF: begin
        res  = {st_ff.flags[`MCA_ST_C], opnd[7:1]};
        resC = opnd[0];
        updC = 1'b1;
      end
      OP_MOVWF: begin
        res = st_ff.w;
        toW = 1'b0;
        toF = 1'b1;
      end
      OP_MOVLW: begin
        res = lit;
        toW = 1'b1;
        toF = 1'b0;
      end
      OP_GOTO: begin
        toW = 1'b0;
        toF = 1'b0;
      end
    endcase
  end

  assign branch = exec && ((op == OP_GOTO) ||
                  (toF && effAddr == `MCA_ADR_PCL));

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.phase = (st_ff.phase == PH_LAST) ? '0 : st_ff.phase + 1'b1;
    nxt_st.pbus.re = 1'b1;
    // Write strobe is a single-clock pulse
    nxt_st.dbus.we = 1'b0;
    if (st_ff.phase == PH_ADDR) begin
      nxt_st.dbus.addr = effAddr;
      nxt_st.dbus.re   = st_ff.irValid && readsFile(op) && !isInt;
    end
    if (st_ff.phase == PH_LAST) begin
      nxt_st.dbus.re = 1'b0;
      // Fetch overlaps execution
      nxt_st.ir      = progData;
      nxt_st.irValid = 1'b1;
      nxt_st.pc      = st_ff.pc + 1'b1;
    end
    if (exec) begin
      if (toW) begin
        nxt_st.w = res;
      end
      if (toF) begin
        unique case (effAddr)
          `MCA_ADR_PCL:    nxt_st.pc[7:0] = res;
          `MCA_ADR_STATUS: nxt_st.flags   = res[2:0];
          `MCA_ADR_FSR:    nxt_st.fsr     = res;
          `MCA_ADR_INDF:   nxt_st.fsr     = st_ff.fsr;
          default: begin
            nxt_st.dbus.we    = 1'b1;
            nxt_st.dbus.wdata = res;
          end
        endcase
      end
      if (updC) begin
        nxt_st.flags[`MCA_ST_C] = resC;
      end
      if (updDC) begin
        nxt_st.flags[`MCA_ST_DC] = nib5[4];
      end
      if (updZ) begin
        nxt_st.flags[`MCA_ST_Z] = (res == 8'h00);
      end
      if (op == OP_GOTO) begin
        nxt_st.pc = {st_ff.pc[12:10], st_ff.ir[9:0]};
      end
      if (branch) begin
        nxt_st.irValid = 1'b0;
      end
    end
    if (st_ff.phase == PH_LAST) begin
      nxt_st.pbus.addr = nxt_st.pc;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{phase: '0, pc: `MCA_RST_PC, ir: '0, irValid: 1'b0,
                 w: `MCA_RST_W, flags: `MCA_RST_FLAGS, fsr: `MCA_RST_FSR,
                 pbus: '{addr: `MCA_RST_PC, re: 1'b0},
                 dbus: '{addr: 8'h00, wdata: 8'h00, we: 1'b0, re: 1'b0}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign progBus  = st_ff.pbus;
  assign dataBus  = st_ff.dbus;
  assign wOut     = st_ff.w;
  assign flagsOut = st_ff.flags;

  a_fetch_stable: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.phase != '0) |-> $stable(progBus.addr))
    else $error("Program address moved inside an instruction cycle");

  a_ir_prefetch: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.phase == PH_LAST) |=> (st_ff.ir == $past(progData)) &&
    (st_ff.irValid == !$past(branch)))
    else $error("Prefetched word not loaded at cycle end");

  a_cycle_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.phase == PH_LAST) |=> (st_ff.phase == '0) ##1 (st_ff.phase == PH_ADDR))
    else $error("Instruction cycle length wrong");

  a_goto_flush: assert property (@(posedge mclk) disable iff (!arst_n)
    (exec && op == OP_GOTO) |=> !st_ff.irValid &&
    (progBus.addr[9:0] == $past(st_ff.ir[9:0])))
    else $error("Branch did not flush or redirect fetch");

  a_we_window: assert property (@(posedge mclk) disable iff (!arst_n)
    dataBus.we |-> (st_ff.phase == '0) && !dataBus.re ##1 !dataBus.we)
    else $error("Data write outside its slot");

  a_indirect_addr: assert property (@(posedge mclk) disable iff (!arst_n)
    (st_ff.phase == PH_ADDR && lit == `MCA_ADR_INDF) |=> (dataBus.addr == st_ff.fsr))
    else $error("Indirect address not taken from pointer");

  a_addlw_sum: assert property (@(posedge mclk) disable iff (!arst_n)
    (exec && op == OP_ADDLW) |=> (wOut == 8'($past(st_ff.w) + $past(lit))))
    else $error("Literal add result wrong");

  a_sub_borrow: assert property (@(posedge mclk) disable iff (!arst_n)
    (exec && op == OP_SUBLW) |=>
    (flagsOut[`MCA_ST_C] == ($past(lit) >= $past(st_ff.w))) &&
    (flagsOut[`MCA_ST_DC] == ($past(lit[3:0]) >= $past(st_ff.w[3:0]))))
    else $error("Subtract borrow flags wrong");

  a_zero_flag: assert property (@(posedge mclk) disable iff (!arst_n)
    (exec && updZ) |=> (flagsOut[`MCA_ST_Z] == ($past(res) == 8'h00)))
    else $error("Zero flag disagrees with result");

  a_flags_kept: assert property (@(posedge mclk) disable iff (!arst_n)
    (exec && op inside {OP_MOVWF, OP_MOVLW, OP_GOTO} &&
     !(toF && effAddr == `MCA_ADR_STATUS)) |=> $stable(flagsOut))
    else $error("Flags changed by a non-flag instruction");

endmodule : mca_core

// ===== rtl/mca_pkg.sv
`include "mca_regs.svh"

package mca_pkg;

  typedef enum logic [3:0] {
    OP_ADDWF = 4'h0,
    OP_SUBWF = 4'h1,
    OP_ANDWF = 4'h2,
    OP_IORWF = 4'h3,
    OP_XORWF = 4'h4,
    OP_MOVF  = 4'h5,
    OP_MOVWF = 4'h6,
    OP_COMF  = 4'h7,
    OP_INCF  = 4'h8,
    OP_DECF  = 4'h9,
    OP_RLF   = 4'hA,
    OP_RRF   = 4'hB,
    OP_ADDLW = 4'hC,
    OP_SUBLW = 4'hD,
    OP_MOVLW = 4'hE,
    OP_GOTO  = 4'hF
  } mca_op_t;

  typedef struct packed {
    logic [`MCA_PC_W-1:0] addr;
    logic                 re;
  } mca_pbus_t;

  typedef struct packed {
    logic [7:0]           addr;
    logic [`MCA_DW_W-1:0] wdata;
    logic                 we;
    logic                 re;
  } mca_dbus_t;

  typedef struct packed {
    logic [`MCA_PH_W-1:0] phase;
    logic [`MCA_PC_W-1:0] pc;
    logic [`MCA_IW_W-1:0] ir;
    logic                 irValid;
    logic [`MCA_DW_W-1:0] w;
    logic [2:0]           flags;
    logic [7:0]           fsr;
    mca_pbus_t            pbus;
    mca_dbus_t            dbus;
  } mca_state_t;

endpackage : mca_pkg

// ===== rtl/mca_regs.svh
`ifndef MCA_REGS_SVH
`define MCA_REGS_SVH

// Data memory addresses of the core's own registers
`define MCA_ADR_INDF   8'h00
`define MCA_ADR_PCL    8'h02
`define MCA_ADR_STATUS 8'h03
`define MCA_ADR_FSR    8'h04

// Status register bit positions
`define MCA_ST_C  0
`define MCA_ST_DC 1
`define MCA_ST_Z  2

// Reset values
`define MCA_RST_PC     13'h0000
`define MCA_RST_W      8'h00
`define MCA_RST_FSR    8'h00
`define MCA_RST_FLAGS  3'h0

// Widths
`define MCA_PC_W   13
`define MCA_IW_W   14
`define MCA_DW_W   8
`define MCA_PH_W   4

// Instruction cycle timing
`define MCA_CYC_NS   200
`define MCA_CLK_NS   20
`define MCA_CYC_CLKS ((`MCA_CYC_NS + `MCA_CLK_NS - 1) / `MCA_CLK_NS)

`endif

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "mca_regs.svh"

module tb_top;
  import mca_pkg::*;

  typedef struct packed {
    mca_op_t    op;
    logic       d;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] expW;
    logic [7:0] expF;
    logic [2:0] expFl;
  } mca_row_t;

  localparam int CYC = 10;

  logic            mclk;
  logic            arst_n;
  mca_pbus_t       progBus;
  mca_dbus_t       dataBus;
  logic [13:0]     progData = 14'h0000;
  logic [7:0]      dataRdata = 8'h00;
  logic [7:0]      wOut;
  logic [2:0]      flagsOut;
  logic [13:0]     rom [0:15];
  logic [7:0]      ram [0:255];
  int              err_total;
  int              num_checks;
  int              k;
  logic            lit;

  mca_row_t rows [18] = '{
    '{OP_ADDWF, 1'b1, 8'h0F, 8'h01, 8'h0F, 8'h10, 3'h2},
    '{OP_ADDWF, 1'b0, 8'h80, 8'h80, 8'h00, 8'h80, 3'h5},
    '{OP_SUBWF, 1'b0, 8'h05, 8'h05, 8'h00, 8'h05, 3'h7},
    '{OP_SUBWF, 1'b0, 8'h01, 8'h10, 8'h0F, 8'h10, 3'h1},
    '{OP_SUBWF, 1'b0, 8'h01, 8'h00, 8'hFF, 8'h00, 3'h0},
    '{OP_ANDWF, 1'b0, 8'hF0, 8'h0F, 8'h00, 8'h0F, 3'h4},
    '{OP_IORWF, 1'b0, 8'hF0, 8'h0F, 8'hFF, 8'h0F, 3'h0},
    '{OP_XORWF, 1'b0, 8'hAA, 8'hAA, 8'h00, 8'hAA, 3'h4},
    '{OP_MOVF,  1'b0, 8'h55, 8'h00, 8'h00, 8'h00, 3'h4},
    '{OP_MOVWF, 1'b1, 8'h3C, 8'h00, 8'h3C, 8'h3C, 3'h0},
    '{OP_COMF,  1'b1, 8'h00, 8'hFF, 8'h00, 8'h00, 3'h4},
    '{OP_INCF,  1'b0, 8'h00, 8'hFF, 8'h00, 8'hFF, 3'h4},
    '{OP_DECF,  1'b0, 8'h00, 8'h01, 8'h00, 8'h01, 3'h4},
    '{OP_RLF,   1'b0, 8'h00, 8'h81, 8'h02, 8'h81, 3'h1},
    '{OP_RRF,   1'b0, 8'h00, 8'h01, 8'h00, 8'h01, 3'h1},
    '{OP_ADDLW, 1'b0, 8'hFF, 8'h01, 8'h00, 8'h01, 3'h7},
    '{OP_SUBLW, 1'b0, 8'h03, 8'h02, 8'hFF, 8'h02, 3'h0},
    '{OP_MOVLW, 1'b0, 8'h00, 8'h7E, 8'h7E, 8'h7E, 3'h0}
  };

  mca_core #(.CYC_CLKS(CYC)) i_mca_core (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .progBus   (progBus),
    .progData  (progData),
    .dataBus   (dataBus),
    .dataRdata (dataRdata),
    .wOut      (wOut),
    .flagsOut  (flagsOut)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Memories; unselected lines show the inverse of their last value
  always @(posedge mclk) begin
    progData  <= progBus.re ? rom[progBus.addr[3:0]] : ~progData;
    dataRdata <= dataBus.re ? ram[dataBus.addr] : ~dataRdata;
    if (dataBus.we === 1'b1) ram[dataBus.addr] <= dataBus.wdata;
  end

  function automatic logic [13:0] enc(mca_op_t op, logic d, logic [7:0] v);
    return {op, 1'b0, d, v};
  endfunction : enc

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic chk(input string m, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Load program, reset, run n instruction cycles
  task automatic run(input logic [13:0] p [$], input int n);
    for (int i = 0; i < 16; i++) rom[i] = (i < p.size()) ? p[i] : enc(OP_GOTO, 1'b0, 8'(i));
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("reset w", wOut, 8'h00);
    chk("reset bus", {flagsOut, progBus.re, dataBus.we, dataBus.re, 2'h0}, 8'h00);
    arst_n <= 1'b1;
    repeat (n * CYC) @(posedge mclk);
  endtask : run

  // Clocks until the fetch address moves
  task automatic gap(output int c);
    logic [12:0] a;
    a = progBus.addr;
    for (c = 1; c <= 3 * CYC; c++) begin
      @(posedge mclk);
      #1;
      if (progBus.addr !== a) return;
    end
    err_total++;
    $display("CHECK FAILED t=%0t fetch address stuck", $time);
    finish_test();
  endtask : gap

  initial begin
    arst_n    = 1'b0;
    err_total = 0;
    num_checks = 0;
    for (int i = 0; i < 256; i++) ram[i] = 8'(i);
    foreach (rows[i]) begin
      ram[8'h20] = rows[i].b;
      lit = rows[i].op inside {OP_ADDLW, OP_SUBLW, OP_MOVLW};
      run('{enc(OP_MOVLW, 1'b0, rows[i].a),
            enc(rows[i].op, rows[i].d, lit ? rows[i].b : 8'h20)}, 5);
      chk("w", wOut, rows[i].expW);
      chk("file", ram[8'h20], rows[i].expF);
      chk("flags", 8'(flagsOut), 8'(rows[i].expFl));
    end
    // One fetch per instruction cycle, straight line code
    run('{enc(OP_MOVLW, 1'b0, 8'h01), enc(OP_MOVLW, 1'b0, 8'h02),
          enc(OP_MOVLW, 1'b0, 8'h03), enc(OP_MOVLW, 1'b0, 8'h04)}, 0);
    gap(k);
    gap(k);
    gap(k);
    chk("fetch period", 8'(k), 8'(CYC));
    repeat (4 * CYC) @(posedge mclk);
    chk("straight w", wOut, 8'h04);
    // Branch discards the prefetched word
    run('{enc(OP_MOVLW, 1'b0, 8'h11), enc(OP_GOTO, 1'b0, 8'h04), enc(OP_MOVLW, 1'b0, 8'h22),
          enc(OP_MOVLW, 1'b0, 8'h33), enc(OP_ADDLW, 1'b0, 8'h01)}, 8);
    chk("branch", wOut, 8'h12);
    // Writing the program counter low byte is a branch too
    run('{enc(OP_MOVLW, 1'b0, 8'h04), enc(OP_MOVWF, 1'b1, 8'h02), enc(OP_MOVLW, 1'b0, 8'h22),
          enc(OP_MOVLW, 1'b0, 8'h33), enc(OP_ADDLW, 1'b0, 8'h01)}, 8);
    chk("pc write", wOut, 8'h05);
    // Status write and indirect write through the pointer
    ram[8'h20] = 8'h00;
    run('{enc(OP_MOVLW, 1'b0, 8'h07), enc(OP_MOVWF, 1'b1, 8'h03), enc(OP_MOVLW, 1'b0, 8'h20),
          enc(OP_MOVWF, 1'b1, 8'h04), enc(OP_MOVLW, 1'b0, 8'h99),
          enc(OP_MOVWF, 1'b1, 8'h00)}, 9);
    chk("status", 8'(flagsOut), 8'h07);
    chk("indirect", ram[8'h20], 8'h99);
    chk("status ram", ram[8'h03], 8'h03);
    finish_test();
  end

endmodule : tb_top
